// File: pkg/ubfc_pkg.sv
/*
 Constants for the baud divisor and frame configuration block: register
 byte offsets, field positions, reset values and detector thresholds.
 Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
*/
package ubfc_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_BDH   = 8'h00;
	localparam logic [7:0] ADDR_BDL   = 8'h04;
	localparam logic [7:0] ADDR_C1    = 8'h08;
	localparam logic [7:0] ADDR_C2    = 8'h0C;
	localparam logic [7:0] ADDR_S1    = 8'h10;
	localparam logic [7:0] ADDR_S2    = 8'h14;
	localparam logic [7:0] ADDR_C3    = 8'h18;
	localparam logic [7:0] ADDR_DATA  = 8'h1C;
	// Reset values
	localparam logic [7:0] RST_BDH    = 8'h00;
	localparam logic [7:0] RST_BDL    = 8'h04;
	localparam logic [7:0] RST_C1     = 8'h00;
	localparam logic [7:0] RST_C2     = 8'h00;
	// Divisor high register fields
	localparam int BDH_LBK_IE  = 7;
	localparam int BDH_EDGE_IE = 6;
	localparam int BDH_HI_MSB  = 4;
	// Frame control one fields
	localparam int C1_LOOP_SELECT = 7;
	localparam int C1_SWAI  = 6;
	localparam int C1_RECEIVER_SOURCE_SELECT  = 5;
	localparam int C1_M     = 4;
	localparam int C1_WAKE  = 3;
	localparam int C1_ILT   = 2;
	localparam int C1_PE    = 1;
	localparam int C1_PT    = 0;
	// Frame control two fields
	localparam int C2_TE = 3;
	localparam int C2_RE = 2;
	// Status fields
	localparam int S1_IDLE = 4;
	localparam int S1_PF   = 0;
	localparam int S2_LBK  = 7;
	localparam int S2_EDGE = 6;
	// Sample ticks per bit and detector thresholds in sample ticks
	localparam logic [3:0] TICK_LAST  = 4'hF;
	localparam logic [7:0] IDLE_TK_8  = 8'hA0;
	localparam logic [7:0] IDLE_TK_9  = 8'hB0;
	localparam logic [7:0] BRK_TK_8   = 8'hA0;
	localparam logic [7:0] BRK_TK_9   = 8'hB0;
	localparam logic [1:0] HTRANS_NSQ = 2'h2;
endpackage

// File: verilog/ubfc_top.sv
/*
 Baud divisor and frame configuration block with its AHB-Lite register slave,
 baud generator, line routing, parity, break, edge and idle detection.
 Assumes a single 100 MHz clock, zero-wait single-word bus accesses, and an
 external shifter that supplies the transmit serial bit and received characters.
*/
// Our own choices: the register addresses and the AHB-Lite register port.
// Summary of operation
// - Eight byte-wide registers: divisor, options, status and data.
// - Divisor high write is buffered; working high loads on low write.
// - High bits 4:0 and low bits 7:0 form one 13-bit divisor.
// - Low resets non-zero; generator idle until TE or RE written one.
// - Divisor zero stops the baud generator.
// - Baud rate equals bus clock over sixteen times divisor.
// - High bit 7 enables interrupt from the line break flag.
// - High bit 6 enables interrupt from the receive edge flag.
// - Loop select zero: separate receive and transmit pins.
// - Loop select one: transmitter feeds receiver, receive pin unused.
// - Receiver source only matters while loop select is one.
// - Loop with source zero: internal loopback, receive pin unused.
// - Loop with source one: single wire on transmit pin.
// - Wait-stop one freezes the clocks in wait mode.
// - Length bit selects eight or nine data bits, LSB first.
// - Wake bit selects idle-line or address-mark wakeup.
// - Idle type sets idle count start after start or stop bit.
// - Parity enable generates and checks parity in the MSB.
// - Parity type zero even, one odd, over the character.
// - Transmitter enable makes the transmit pin an output.
`timescale 1ns/1ns
module ubfc_top (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        rxd_i,
	input  wire logic        txd_i,
	output logic             txd_o,
	output logic             txd_oe_n_o,
	input  wire logic        tx_serial_i,
	input  wire logic        rx_stop_i,
	input  wire logic [8:0]  rx_char_i,
	input  wire logic        rx_char_valid_i,
	input  wire logic        wait_mode_i,
	output logic             rx_line_o,
	output logic             sample_tick_o,
	output logic             bit_tick_o,
	output logic             char_9bit_o,
	output logic             wake_addr_mark_o,
	output logic             parity_en_o,
	output logic             parity_bit_o,
	output logic             irq_o
);
	typedef struct packed {
		logic [7:0]  bdh_buf;
		logic [4:0]  br_hi;
		logic [7:0]  br_lo;
		logic [7:0]  c1;
		logic [7:0]  c2;
		logic [7:0]  c3;
		logic [7:0]  data;
		logic        lbk_f;
		logic        edge_f;
		logic        idle_f;
		logic        perr_f;
		logic        armed;
		logic [12:0] br_cnt;
		logic [3:0]  tick_cnt;
		logic        sample_tick;
		logic        bit_tick;
		logic        wr_pend;
		logic [2:0]  wr_idx;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
		logic [1:0]  rxd_s;
		logic [1:0]  txd_s;
		logic        rx_line;
		logic        rx_prev;
		logic [7:0]  low_cnt;
		logic [7:0]  high_cnt;
		logic        idle_run;
		logic        txd;
		logic        txd_oe_n;
		logic        parity_bit;
		logic        irq;
	} ubfc_state_t;

	ubfc_state_t s_ff;
	ubfc_state_t nxt_s;
	logic [12:0] br_val;
	logic        run_c;
	logic        mapped_c;
	logic [7:0]  idle_thr;
	logic [7:0]  brk_thr;

	// Working divisor and generator run condition
	assign br_val   = {s_ff.br_hi, s_ff.br_lo};
	assign run_c    = s_ff.armed && (br_val != 13'h0000)
		&& !(wait_mode_i && s_ff.c1[ubfc_pkg::C1_SWAI]);
	assign mapped_c = (haddr_i[31:5] == 27'h0000000) && (haddr_i[1:0] == 2'h0);
	assign idle_thr = s_ff.c1[ubfc_pkg::C1_M] ? ubfc_pkg::IDLE_TK_9 : ubfc_pkg::IDLE_TK_8;
	assign brk_thr  = s_ff.c1[ubfc_pkg::C1_M] ? ubfc_pkg::BRK_TK_9 : ubfc_pkg::BRK_TK_8;

	// Read multiplexer over the eight register words
	function automatic logic [7:0] ubfc_rd(input ubfc_state_t st, input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			3'h0: v = {st.bdh_buf[7:6], 1'b0, st.bdh_buf[4:0]};
			3'h1: v = st.br_lo;
			3'h2: v = st.c1;
			3'h3: v = st.c2;
			3'h4: v = {3'h0, st.idle_f, 3'h0, st.perr_f};
			3'h5: v = {st.lbk_f, st.edge_f, 6'h00};
			3'h6: v = st.c3;
			3'h7: v = st.data;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Next state: bus writes, generator, routing, detectors, outputs
	always_comb begin
		logic [7:0] wd;
		logic       rd_req;
		wd     = hwdata_i[7:0];
		rd_req = 1'b0;
		nxt_s  = s_ff;
		// Data phase of a write applies the byte to its register
		nxt_s.wr_pend = 1'b0;
		if (s_ff.wr_pend) begin
			case (s_ff.wr_idx)
				3'h0: nxt_s.bdh_buf = wd;
				3'h1: begin
					nxt_s.br_lo = wd;
					nxt_s.br_hi = s_ff.bdh_buf[ubfc_pkg::BDH_HI_MSB:0];
				end
				3'h2: nxt_s.c1 = wd;
				3'h3: begin
					nxt_s.c2 = wd;
					if (wd[ubfc_pkg::C2_TE] || wd[ubfc_pkg::C2_RE]) begin
						nxt_s.armed = 1'b1;
					end
				end
				3'h6: nxt_s.c3 = wd;
				3'h7: nxt_s.data = wd;
				default: nxt_s.c3 = s_ff.c3;
			endcase
		end
		// Address phase of a mapped transfer
		if (hsel_i && hready_i && (htrans_i == ubfc_pkg::HTRANS_NSQ)) begin
			if (hwrite_i && mapped_c) begin
				nxt_s.wr_pend = 1'b1;
				nxt_s.wr_idx  = haddr_i[4:2];
			end
			rd_req = !hwrite_i;
		end
		nxt_s.hreadyout = 1'b1;
		nxt_s.hresp     = 1'b0;
		// Baud generator: a tick every divisor count, a bit every sixteen ticks
		nxt_s.sample_tick = 1'b0;
		nxt_s.bit_tick    = 1'b0;
		if (!run_c) begin
			nxt_s.br_cnt = 13'h0000;
		end else if (s_ff.br_cnt >= br_val - 13'h0001) begin
			nxt_s.br_cnt      = 13'h0000;
			nxt_s.sample_tick = 1'b1;
			nxt_s.tick_cnt    = s_ff.tick_cnt + 4'h1;
			nxt_s.bit_tick    = (s_ff.tick_cnt == ubfc_pkg::TICK_LAST);
		end else begin
			nxt_s.br_cnt = s_ff.br_cnt + 13'h0001;
		end
		// Pin synchronisers
		nxt_s.rxd_s = {s_ff.rxd_s[0], rxd_i};
		nxt_s.txd_s = {s_ff.txd_s[0], txd_i};
		// Receiver input routing
		if (!s_ff.c1[ubfc_pkg::C1_LOOP_SELECT]) begin
			nxt_s.rx_line = s_ff.rxd_s[1];
		end else if (!s_ff.c1[ubfc_pkg::C1_RECEIVER_SOURCE_SELECT]) begin
			nxt_s.rx_line = tx_serial_i;
		end else begin
			nxt_s.rx_line = s_ff.txd_s[1];
		end
		nxt_s.rx_prev = s_ff.rx_line;
		// Transmit pin drive
		nxt_s.txd      = s_ff.c2[ubfc_pkg::C2_TE] ? tx_serial_i : 1'b1;
		nxt_s.txd_oe_n = !s_ff.c2[ubfc_pkg::C2_TE];
		// Parity for the transmit character: MSB of eight or nine bits
		nxt_s.parity_bit = (s_ff.c1[ubfc_pkg::C1_M] ? ^s_ff.data : ^s_ff.data[6:0])
			^ s_ff.c1[ubfc_pkg::C1_PT];
		// Line break: low for ten or eleven bit times
		if (s_ff.rx_line) begin
			nxt_s.low_cnt = 8'h00;
		end else if (s_ff.sample_tick && (s_ff.low_cnt != brk_thr)) begin
			nxt_s.low_cnt = s_ff.low_cnt + 8'h01;
		end
		// Idle line: high count restarts after start bit or after stop bit
		if (!s_ff.rx_line) begin
			nxt_s.high_cnt = 8'h00;
			nxt_s.idle_run = !s_ff.c1[ubfc_pkg::C1_ILT];
		end else begin
			if (rx_stop_i) begin
				nxt_s.idle_run = 1'b1;
			end
			if (s_ff.idle_run && s_ff.sample_tick && (s_ff.high_cnt != idle_thr)) begin
				nxt_s.high_cnt = s_ff.high_cnt + 8'h01;
			end
		end
		// Flag clears by writing one, then sets, so a new event wins
		if (s_ff.wr_pend && (s_ff.wr_idx == 3'h4)) begin
			nxt_s.idle_f = s_ff.idle_f && !wd[ubfc_pkg::S1_IDLE];
			nxt_s.perr_f = s_ff.perr_f && !wd[ubfc_pkg::S1_PF];
		end
		if (s_ff.wr_pend && (s_ff.wr_idx == 3'h5)) begin
			nxt_s.lbk_f  = s_ff.lbk_f && !wd[ubfc_pkg::S2_LBK];
			nxt_s.edge_f = s_ff.edge_f && !wd[ubfc_pkg::S2_EDGE];
		end
		if (s_ff.sample_tick && (s_ff.low_cnt == brk_thr - 8'h01)) begin
			nxt_s.lbk_f = 1'b1;
		end
		if (s_ff.rx_prev && !s_ff.rx_line) begin
			nxt_s.edge_f = 1'b1;
		end
		if (s_ff.sample_tick && s_ff.rx_line && s_ff.idle_run && (s_ff.high_cnt == idle_thr - 8'h01)) begin
			nxt_s.idle_f = 1'b1;
		end
		if (rx_char_valid_i && s_ff.c1[ubfc_pkg::C1_PE]) begin
			if ((s_ff.c1[ubfc_pkg::C1_M] ? ^rx_char_i : ^rx_char_i[7:0]) != s_ff.c1[ubfc_pkg::C1_PT]) begin
				nxt_s.perr_f = 1'b1;
			end
		end
		// Interrupt request from enabled flags
		nxt_s.irq = (s_ff.bdh_buf[ubfc_pkg::BDH_LBK_IE] && s_ff.lbk_f)
			|| (s_ff.bdh_buf[ubfc_pkg::BDH_EDGE_IE] && s_ff.edge_f);
		// Read data is sampled from the updated state for the data phase
		if (rd_req) begin
			nxt_s.hrdata = mapped_c ? {24'h000000, ubfc_rd(nxt_s, haddr_i[4:2])} : 32'h00000000;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_ff           <= '0;
			s_ff.bdh_buf   <= ubfc_pkg::RST_BDH;
			s_ff.br_hi     <= ubfc_pkg::RST_BDH[4:0];
			s_ff.br_lo     <= ubfc_pkg::RST_BDL;
			s_ff.c1        <= ubfc_pkg::RST_C1;
			s_ff.c2        <= ubfc_pkg::RST_C2;
			s_ff.hreadyout <= 1'b1;
			s_ff.rxd_s     <= 2'h3;
			s_ff.txd_s     <= 2'h3;
			s_ff.rx_line   <= 1'b1;
			s_ff.rx_prev   <= 1'b1;
			s_ff.idle_run  <= 1'b1;
			s_ff.txd       <= 1'b1;
			s_ff.txd_oe_n  <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state register
	assign hrdata_o         = s_ff.hrdata;
	assign hreadyout_o      = s_ff.hreadyout;
	assign hresp_o          = s_ff.hresp;
	assign txd_o            = s_ff.txd;
	assign txd_oe_n_o       = s_ff.txd_oe_n;
	assign rx_line_o        = s_ff.rx_line;
	assign sample_tick_o    = s_ff.sample_tick;
	assign bit_tick_o       = s_ff.bit_tick;
	assign char_9bit_o      = s_ff.c1[ubfc_pkg::C1_M];
	assign wake_addr_mark_o = s_ff.c1[ubfc_pkg::C1_WAKE];
	assign parity_en_o      = s_ff.c1[ubfc_pkg::C1_PE];
	assign parity_bit_o     = s_ff.parity_bit;
	assign irq_o            = s_ff.irq;

	// Checks on the block's own behaviour
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	sequence bdh_write_s;
		s_ff.wr_pend && (s_ff.wr_idx == 3'h0);
	endsequence
	sequence bdl_write_s;
		s_ff.wr_pend && (s_ff.wr_idx == 3'h1);
	endsequence

	hi_buffer_a: assert property (bdh_write_s |=> $stable(s_ff.br_hi))
		else $error("working divisor high changed on high write");
	lo_commit_a: assert property (bdl_write_s |=> (br_val == {$past(s_ff.bdh_buf[4:0]), $past(hwdata_i[7:0])}))
		else $error("divisor not committed on low write");
	not_armed_a: assert property (!s_ff.armed |=> !s_ff.sample_tick)
		else $error("generator ran before enable");
	zero_div_a: assert property ((br_val == 13'h0000) |=> !s_ff.sample_tick)
		else $error("generator ran with zero divisor");
	tick_period_a: assert property ((s_ff.sample_tick && run_c && br_val == 13'h0002)
		##1 (run_c && br_val == 13'h0002) |-> !s_ff.sample_tick ##1 s_ff.sample_tick)
		else $error("sample tick spacing differs from divisor");
	bit_tick_a: assert property (s_ff.bit_tick |-> s_ff.sample_tick && (s_ff.tick_cnt == 4'h0))
		else $error("bit tick not on sixteenth sample tick");
	wait_freeze_a: assert property ((wait_mode_i && s_ff.c1[ubfc_pkg::C1_SWAI]) |=> !s_ff.sample_tick)
		else $error("generator ran during wait freeze");
	lbk_irq_a: assert property ((s_ff.lbk_f && s_ff.bdh_buf[ubfc_pkg::BDH_LBK_IE]) |=> irq_o)
		else $error("break interrupt missing");
	edge_irq_a: assert property ((s_ff.edge_f && s_ff.bdh_buf[ubfc_pkg::BDH_EDGE_IE]) |=> irq_o)
		else $error("edge interrupt missing");
	irq_masked_a: assert property ((!s_ff.bdh_buf[ubfc_pkg::BDH_LBK_IE] && !s_ff.bdh_buf[ubfc_pkg::BDH_EDGE_IE]) |=> !irq_o)
		else $error("interrupt while both enables off");
	normal_rx_a: assert property (!s_ff.c1[ubfc_pkg::C1_LOOP_SELECT] |=> (rx_line_o == $past(s_ff.rxd_s[1])))
		else $error("receiver not on receive pin");
	loopback_a: assert property ((s_ff.c1[ubfc_pkg::C1_LOOP_SELECT] && !s_ff.c1[ubfc_pkg::C1_RECEIVER_SOURCE_SELECT])
		|=> (rx_line_o == $past(tx_serial_i)))
		else $error("internal loopback not routed");
	single_wire_a: assert property ((s_ff.c1[ubfc_pkg::C1_LOOP_SELECT] && s_ff.c1[ubfc_pkg::C1_RECEIVER_SOURCE_SELECT])
		|=> (rx_line_o == $past(s_ff.txd_s[1])))
		else $error("single wire not routed");
	tx_drive_a: assert property (s_ff.c2[ubfc_pkg::C2_TE] |=> !txd_oe_n_o ##1 !txd_oe_n_o || !s_ff.c2[ubfc_pkg::C2_TE])
		else $error("transmit pin not driven");
	parity_chk_a: assert property ((rx_char_valid_i && s_ff.c1[ubfc_pkg::C1_PE] && !s_ff.c1[ubfc_pkg::C1_M]
		&& (^rx_char_i[7:0] != s_ff.c1[ubfc_pkg::C1_PT])) |=> s_ff.perr_f)
		else $error("parity error not flagged");
	bus_ready_a: assert property (hreadyout_o && !hresp_o)
		else $error("slave stalled or errored");
	// Pin release without the transmitter, idle count start and edge capture
	tx_release_a: assert property (!s_ff.c2[ubfc_pkg::C2_TE] |=> (txd_oe_n_o && txd_o))
		else $error("transmit pin not released");
	idle_start_a: assert property ((!s_ff.rx_line && !s_ff.c1[ubfc_pkg::C1_ILT]) |=> s_ff.idle_run)
		else $error("idle count not armed after start bit");
	idle_stop_a: assert property ((!s_ff.rx_line && s_ff.c1[ubfc_pkg::C1_ILT]) |=> !s_ff.idle_run)
		else $error("idle count armed before stop bit");
	edge_flag_a: assert property ((s_ff.rx_prev && !s_ff.rx_line) |=> s_ff.edge_f)
		else $error("receive edge flag not set");
endmodule

// File: dv/ubfc_peer.sv
/*
 Remote serial peer on the receive pin: idle high, sends one NRZ frame per go
 pulse and holds the line low while brk_i is high.
 Assumes the bench clock and a bit time given in clock cycles.
*/
`timescale 1ns/1ns
module ubfc_peer (
	input  wire logic        ref_clk_i,
	input  wire logic        go_i,
	input  wire logic        brk_i,
	input  wire logic [8:0]  char_i,
	input  wire logic        nine_i,
	input  wire logic [15:0] bit_cyc_i,
	output logic             rxd_o,
	output logic             busy_o
);
	logic        line_ff;
	logic [10:0] frame;
	int          nb;
	// Break forces the line low, otherwise the frame level shows
	assign rxd_o = line_ff & ~brk_i;
	// Start bit, data LSB first, optional ninth bit, stop bit
	initial begin
		line_ff = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge ref_clk_i);
			if (go_i === 1'b1) begin
				busy_o <= 1'b1;
				frame = nine_i ? {1'b1, char_i, 1'b0} : {2'b11, char_i[7:0], 1'b0};
				nb = nine_i ? 11 : 10;
				for (int i = 0; i < nb; i++) begin
					line_ff <= frame[i];
					repeat (bit_cyc_i) @(posedge ref_clk_i);
				end
				busy_o <= 1'b0;
			end
		end
	end
endmodule

// File: dv/tb_ubfc_top.sv
/*
 Self-checking bench for ubfc_top: AHB-Lite master tasks, random and corner cases.
 Assumes ubfc_peer drives the receive pin and hready is looped back from hreadyout.
*/
`timescale 1ns/1ns
module tb_ubfc_top;
	logic        ref_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        hsel = 1'b0, hwrite = 1'b0, tx_ser = 1'b1, txd_in = 1'b1;
	logic        wait_m = 1'b0, go = 1'b0, brk = 1'b0, rxv = 1'b0;
	logic [8:0]  rxc = 9'h000;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic        hrdy, hresp, rxd, txd, oe_n, rx_line, s_tk, b_tk, c9, wk, pen, pbit, irq, busy;
	int          seed = 70495, n_fail = 0, n_compared = 0, n;
	logic [12:0] br;
	logic [7:0]  v;
	// Design under test
	ubfc_top u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .rxd_i(rxd), .txd_i(txd_in),
		.txd_o(txd), .txd_oe_n_o(oe_n), .tx_serial_i(tx_ser), .rx_stop_i(1'b0), .rx_char_i(rxc),
		.rx_char_valid_i(rxv), .wait_mode_i(wait_m), .rx_line_o(rx_line), .sample_tick_o(s_tk),
		.bit_tick_o(b_tk), .char_9bit_o(c9), .wake_addr_mark_o(wk), .parity_en_o(pen),
		.parity_bit_o(pbit), .irq_o(irq));
	// Far side serial peer
	ubfc_peer u_peer (.ref_clk_i(ref_clk_i), .go_i(go), .brk_i(brk), .char_i(9'h055), .nine_i(1'b0),
		.bit_cyc_i(16'h0020), .rxd_o(rxd), .busy_o(busy));
	// Clock and watchdog
	initial forever #5 ref_clk_i = ~ref_clk_i;
	initial begin
		#400000;
		n_fail++;
		close_out;
	end
	task close_out;
		if (n_fail == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single AHB-Lite transfer; read data lands in rd
	task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= ubfc_pkg::HTRANS_NSQ;
		hwrite <= wr;
		do @(posedge ref_clk_i); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge ref_clk_i); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	// Cycles up to the next sample or bit tick
	task tick(input logic b, output int k);
		k = 0;
		do begin
			@(negedge ref_clk_i);
			k++;
		end while (k < 20000 && (b ? b_tk : s_tk) !== 1'b1);
	endtask
	task count_tk(output int t);
		t = 0;
		// Let a divisor or freeze change settle before counting
		repeat (3) @(negedge ref_clk_i);
		repeat (200) begin
			@(negedge ref_clk_i);
			if (s_tk === 1'b1) t++;
		end
	endtask
	task send;
		@(posedge ref_clk_i);
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		do @(negedge ref_clk_i); while (busy === 1'b1);
	endtask
	// Expected parity bit over the character below the MSB
	function logic par(input logic [7:0] d, input logic nine, input logic pt);
		return (nine ? ^d : ^d[6:0]) ^ pt;
	endfunction
	// Expected parity error: ones over the whole character against the type
	function logic perr(input logic [8:0] c, input logic nine, input logic pt);
		return (nine ? ^c : ^c[7:0]) != pt;
	endfunction
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		xfer(1'b0, ubfc_pkg::ADDR_BDH, 8'h00);
		chk(rd, {24'h0, ubfc_pkg::RST_BDH});
		xfer(1'b0, ubfc_pkg::ADDR_BDL, 8'h00);
		chk(rd, {24'h0, ubfc_pkg::RST_BDL});
		xfer(1'b0, ubfc_pkg::ADDR_C1, 8'h00);
		chk(rd, {24'h0, ubfc_pkg::RST_C1});
		xfer(1'b0, 8'h20, 8'h00);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		chk(oe_n, 1'b1);
		count_tk(n);
		chk(n, 0);
		xfer(1'b1, ubfc_pkg::ADDR_C2, 8'h0C);
		tick(1'b0, n);
		tick(1'b0, n);
		chk(n, {24'h0, ubfc_pkg::RST_BDL});
		chk(oe_n, 1'b0);
		// Divisor sweep, high half first then low
		for (int i = 0; i < 4; i++) begin
			br = (i == 0) ? 13'h0001 : {8'h00, 5'($random(seed))} | 13'h0001;
			xfer(1'b1, ubfc_pkg::ADDR_BDH, {3'h0, br[12:8]});
			xfer(1'b1, ubfc_pkg::ADDR_BDL, br[7:0]);
			tick(1'b0, n);
			tick(1'b0, n);
			chk(n, br);
			tick(1'b1, n);
			tick(1'b1, n);
			chk(n, 16 * br);
		end
		xfer(1'b1, ubfc_pkg::ADDR_BDH, 8'h01);
		tick(1'b0, n);
		tick(1'b0, n);
		chk(n, br);
		xfer(1'b0, ubfc_pkg::ADDR_BDH, 8'h00);
		chk(rd, 32'h01);
		xfer(1'b1, ubfc_pkg::ADDR_BDL, 8'h02);
		tick(1'b1, n);
		tick(1'b1, n);
		chk(n, 16 * 258);
		xfer(1'b1, ubfc_pkg::ADDR_BDH, 8'h00);
		xfer(1'b1, ubfc_pkg::ADDR_BDL, 8'h00);
		count_tk(n);
		chk(n, 0);
		xfer(1'b1, ubfc_pkg::ADDR_BDL, 8'h02);
		wait_m <= 1'b1;
		xfer(1'b1, ubfc_pkg::ADDR_C1, 8'h40);
		count_tk(n);
		chk(n, 0);
		xfer(1'b1, ubfc_pkg::ADDR_C1, 8'h00);
		count_tk(n);
		chk(n, 100);
		wait_m <= 1'b0;
		// Random frame formats and parity
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed)) & 8'h7F;
			br = 13'($random(seed));
			xfer(1'b1, ubfc_pkg::ADDR_C1, v);
			xfer(1'b0, ubfc_pkg::ADDR_C1, 8'h00);
			chk(rd, {24'h0, v});
			chk({c9, wk, pen}, {v[4], v[3], v[1]});
			xfer(1'b1, ubfc_pkg::ADDR_C1, {3'h0, br[0], 3'h1, br[1]});
			xfer(1'b1, ubfc_pkg::ADDR_DATA, br[9:2]);
			repeat (2) @(negedge ref_clk_i);
			chk(pbit, par(br[9:2], br[0], br[1]));
			xfer(1'b1, ubfc_pkg::ADDR_S1, 8'h11);
			@(posedge ref_clk_i);
			rxc <= 9'($random(seed));
			rxv <= 1'b1;
			@(posedge ref_clk_i);
			rxv <= 1'b0;
			xfer(1'b0, ubfc_pkg::ADDR_S1, 8'h00);
			chk(rd[0], perr(rxc, br[0], br[1]));
		end
		// Receiver source table: normal, source without loop, loopback, single wire
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, ubfc_pkg::ADDR_C1, (m == 0) ? 8'h00 : (m == 1) ? 8'h20 : (m == 2) ? 8'h80 : 8'hA0);
			repeat (3) begin
				v = 8'($random(seed));
				@(posedge ref_clk_i);
				brk <= v[0];
				tx_ser <= v[1];
				txd_in <= v[2];
				repeat (6) @(negedge ref_clk_i);
				chk(rx_line, (m < 2) ? !v[0] : (m == 2) ? v[1] : v[2]);
				chk(txd, v[1]);
			end
		end
		@(posedge ref_clk_i);
		brk <= 1'b0;
		tx_ser <= 1'b1;
		txd_in <= 1'b1;
		// Loopback ignores a frame on the receive pin
		xfer(1'b1, ubfc_pkg::ADDR_C1, 8'h80);
		repeat (8) @(posedge ref_clk_i);
		xfer(1'b1, ubfc_pkg::ADDR_S2, 8'hC0);
		send;
		xfer(1'b0, ubfc_pkg::ADDR_S2, 8'h00);
		chk(rd[6], 1'b0);
		// Edge flag with and without its enable
		xfer(1'b1, ubfc_pkg::ADDR_C1, 8'h00);
		xfer(1'b1, ubfc_pkg::ADDR_BDH, 8'h40);
		repeat (8) @(posedge ref_clk_i);
		xfer(1'b1, ubfc_pkg::ADDR_S2, 8'hC0);
		repeat (2) @(negedge ref_clk_i);
		chk(irq, 1'b0);
		send;
		chk(irq, 1'b1);
		xfer(1'b1, ubfc_pkg::ADDR_BDH, 8'h00);
		repeat (2) @(negedge ref_clk_i);
		chk(irq, 1'b0);
		xfer(1'b0, ubfc_pkg::ADDR_S2, 8'h00);
		chk(rd[6], 1'b1);
		// Break of 210 ticks at divisor one, checked under the 160 tick bound too
		xfer(1'b1, ubfc_pkg::ADDR_BDH, 8'h80);
		xfer(1'b1, ubfc_pkg::ADDR_BDL, 8'h01);
		@(posedge ref_clk_i);
		brk <= 1'b1;
		repeat (150) @(negedge ref_clk_i);
		chk(irq, 1'b0);
		repeat (60) @(negedge ref_clk_i);
		chk(irq, 1'b1);
		brk <= 1'b0;
		xfer(1'b1, ubfc_pkg::ADDR_S2, 8'hC0);
		repeat (2) @(negedge ref_clk_i);
		chk(irq, 1'b0);
		// Idle count from the start bit; none after a low when counting waits for a stop
		xfer(1'b1, ubfc_pkg::ADDR_S1, 8'h11);
		repeat (200) @(negedge ref_clk_i);
		xfer(1'b0, ubfc_pkg::ADDR_S1, 8'h00);
		chk(rd[4], 1'b1);
		xfer(1'b1, ubfc_pkg::ADDR_C1, 8'h04);
		@(posedge ref_clk_i);
		brk <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		brk <= 1'b0;
		xfer(1'b1, ubfc_pkg::ADDR_S1, 8'h11);
		repeat (200) @(negedge ref_clk_i);
		xfer(1'b0, ubfc_pkg::ADDR_S1, 8'h00);
		chk(rd[4], 1'b0);
		close_out;
	end
endmodule
